// ==== verilog/rwc_pkg.sv ====
// Constants, encodings and register map for the reset and watchdog controller
package rwc_pkg;

  // ===========================================================
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int WDT_OSC_HZ = 31_000;
  localparam int TICK_CYCLES = CLK_HZ / WDT_OSC_HZ;
  localparam int POWER_UP_DELAY_TIMER_MS = 64;
  localparam int POWER_UP_DELAY_TIMER_TICKS = POWER_UP_DELAY_TIMER_MS * WDT_OSC_HZ / 1000;
  localparam int WDT_BASE_MS = 17;
  localparam int WDT_BASE_TICKS = WDT_BASE_MS * WDT_OSC_HZ / 1000;
  localparam int OST_CYCLES = 1024;
  localparam int FILT_NS = 2000;
  localparam int FILT_CYCLES = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [10:0] POWER_UP_DELAY_TIMER_LAST = 11'(POWER_UP_DELAY_TIMER_TICKS - 1);
  localparam logic [9:0] WDT_BASE_LAST = 10'(WDT_BASE_TICKS - 1);
  localparam logic [10:0] OST_LAST = 11'(OST_CYCLES - 1);
  localparam logic [5:0] FILT_LAST = 6'(FILT_CYCLES - 1);

  // ===========================================================
  // Register map and fields
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_CAUSE = 3'h1;
  localparam logic [2:0] ADDR_OPTION = 3'h2;
  localparam logic [2:0] ADDR_WDT_CNT = 3'h3;
  localparam logic [2:0] ADDR_KEEP = 3'h4;

  localparam int OPT_ASSIGN_BIT = 3;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [2:0] STATUS_HI_RST = 3'h0;
  localparam logic [5:0] CAUSE_UNUSED = 6'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] PC_IRQ_VECTOR = 13'h0004;

  // ===========================================================
  // Clock source selection
  typedef enum logic [1:0] {
    RWC_OSC_EXT_RC,
    RWC_OSC_INTERNAL,
    RWC_OSC_EXT_CLOCK,
    RWC_OSC_CRYSTAL
  } rwc_osc_t;

endpackage

// ==== verilog/rwc_reset_ctrl.sv ====
// Reset sequencing, reset cause flags and watchdog for a small microcontroller core
//
// Behaviour
// RULE1: Non-reset registers keep contents across resets
// RULE2: Watchdog wake-up resumes, leaves registers untouched
// RULE3: Reset pin filtered against short low glitches
// RULE4: Device never drives the reset pin
// RULE5: Pin select chooses internal reset or pulled-up pin
// RULE6: Power-on sets both watchdog and sleep flags
// RULE7: Cause flags encode dip, watchdog, wake, pin
// RULE8: Pin-in-sleep or irq wake: expiry 1, sleep 0
// RULE9: True reset loads PC 0; wake resumes after sleep
// RULE10: Status and cause images for power-on, dip, wake
// RULE11: Status images for pin reset and irq wake
// RULE12: Irq wake with enable: one instruction, then vector
// RULE13: Unimplemented status bits read zero
// RULE14: Dip detection holds reset while supply low
// RULE15: Power-up delay after power-on or dip only
// RULE16: Power-up delay disable bit skips the delay
// RULE17: Configurer should enable delay with dip detection
// RULE18: Watchdog shares 8-bit prescaler with timer
// RULE19: Watchdog runs from 31 kHz time base
// RULE20: Watchdog held cleared during oscillator start count
// RULE21: Enabled watchdog runs; period from prescaler bits
// RULE22: Watchdog cleared by disable, command, sleep exit
// RULE23: Watchdog ratios 1:1 to 1:128 by rate code
// RULE24: Power-on cause bit 0 until software sets it
// RULE25: Timeout resets when running, wakes when asleep
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ns

module rwc_reset_ctrl #(
  parameter int TICK_DIV = rwc_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic supply_ok,
  input wire logic dip_detect_en,
  input wire logic ext_reset_pin_in,
  output logic ext_reset_pin_out,
  output logic ext_reset_pin_oe,
  output logic ext_reset_pin_pu,
  input wire logic ext_reset_pin_sel,
  input wire logic power_up_delay_disable,
  input wire logic watchdog_enable,
  input wire rwc_pkg::rwc_osc_t osc_mode,
  input wire logic watchdog_clear_cmd,
  input wire logic sleep_cmd,
  input wire logic [12:0] core_pc,
  input wire logic irq_wake,
  input wire logic global_irq_enable,
  input wire logic core_instr_done,
  input wire logic timer_evt,
  output logic timer_tick,
  output logic core_reset,
  output logic core_halt,
  output logic pc_load,
  output logic [12:0] pc_load_addr,
  output logic vector_jump,
  output logic [12:0] vector_addr,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  import rwc_pkg::*;

  typedef enum logic [1:0] {ST_POWER_UP_DELAY_TIMER, ST_OST, ST_RUN, ST_SLEEP} rwc_state_t;

  localparam logic [9:0] TICK_LAST = 10'(TICK_DIV - 1);

  // Ratio minus one as a mask; watchdog starts at 1:1, timer at 1:2
  function automatic logic [7:0] presc_mask(input logic [2:0] sel, input logic for_timer);
    logic [8:0] ratio;
    ratio = 9'h001 << ({1'b0, sel} + 4'(for_timer));
    return 8'(ratio - 9'h001);
  endfunction

  rwc_state_t st_r;
  logic [1:0] pin_sync_r;
  logic [1:0] sup_sync_r;
  logic [5:0] filt_cnt_r;
  logic pin_rst_r;
  logic [9:0] tick_cnt_r;
  logic [9:0] wd_base_r;
  logic [7:0] presc_r;
  logic [10:0] power_up_delay_timer_cnt_r;
  logic [10:0] ost_cnt_r;
  logic ost_wake_r;
  logic wake_irq_r;
  logic [12:0] sleep_pc_r;
  logic core_reset_r;
  logic pc_load_r;
  logic [12:0] pc_load_addr_r;
  logic vec_pending_r;
  logic vector_jump_r;
  logic [2:0] status_hi_r;
  logic [2:0] status_lo_r;
  logic expiry_n_r;
  logic sleep_n_r;
  logic cause_por_r;
  logic cause_dip_r;
  logic [7:0] option_r;
  logic [7:0] keep_r;
  logic [7:0] rdata_r;

  logic pin_s;
  logic dip_hold;
  logic crystal;
  logic pin_fire;
  logic tick;
  logic base_evt;
  logic presc_evt;
  logic presc_hit;
  logic wd_timeout;
  logic wd_clr;
  logic wd_reset_evt;
  logic sleep_exit;
  logic wake_go;
  logic core_reset_nxt;
  logic assign_wd;

  // ===========================================================
  // Input synchronisers and pin filter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_sync_r <= 2'h3;
      sup_sync_r <= 2'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], ext_reset_pin_in};
      sup_sync_r <= {sup_sync_r[0], supply_ok};
    end
  end

  assign pin_s = pin_sync_r[1];
  assign dip_hold = dip_detect_en && !sup_sync_r[1]; // [RULE14]
  assign crystal = (osc_mode == RWC_OSC_CRYSTAL);
  // Pin is only a reset input when selected; otherwise reset is internal
  assign pin_fire = ext_reset_pin_sel && !pin_s && (filt_cnt_r == FILT_LAST) && !pin_rst_r; // [RULE5]

  // Pulses shorter than the filter time never reach the core
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt_cnt_r <= 6'h00;
      pin_rst_r <= 1'b0;
    end else if (!ext_reset_pin_sel || pin_s) begin // [RULE3]
      filt_cnt_r <= 6'h00;
      pin_rst_r <= 1'b0;
    end else if (filt_cnt_r != FILT_LAST) begin
      filt_cnt_r <= filt_cnt_r + 6'h01;
    end else begin
      pin_rst_r <= 1'b1;
    end
  end

  // Never pulled low by the device; weak pull-up only when used as reset input
  assign ext_reset_pin_out = 1'b0; // [RULE4]
  assign ext_reset_pin_oe = 1'b0; // [RULE4]
  assign ext_reset_pin_pu = ext_reset_pin_sel; // [RULE5]

  // ===========================================================
  // Watchdog time base, ripple stage and shared prescaler
  assign tick = (tick_cnt_r == TICK_LAST);
  assign assign_wd = option_r[OPT_ASSIGN_BIT];
  assign base_evt = tick && (wd_base_r == WDT_BASE_LAST);
  assign presc_evt = assign_wd ? base_evt : timer_evt; // [RULE18]
  assign presc_hit = ((presc_r & presc_mask(option_r[2:0], !assign_wd))
                      == presc_mask(option_r[2:0], !assign_wd)); // [RULE23]
  assign wd_timeout = watchdog_enable && base_evt && (!assign_wd || presc_hit); // [RULE21]
  assign timer_tick = !assign_wd && timer_evt && presc_hit;
  assign sleep_exit = (st_r == ST_SLEEP) && !pin_rst_r && (wd_timeout || irq_wake);
  // Crystal start-up borrows the ripple counter, so it stays cleared meanwhile
  assign wd_clr = !watchdog_enable || watchdog_clear_cmd || (st_r == ST_OST)
                  || core_reset_r || (sleep_exit && !crystal); // [RULE20] [RULE22]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_r <= 10'h000;
    end else if (tick) begin // [RULE19]
      tick_cnt_r <= 10'h000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 10'h001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_base_r <= 10'h000;
    end else if (wd_clr || base_evt) begin
      wd_base_r <= 10'h000;
    end else if (tick) begin
      wd_base_r <= wd_base_r + 10'h001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_r <= 8'h00;
    end else if (wd_clr && assign_wd) begin
      presc_r <= 8'h00;
    end else if (presc_evt) begin
      presc_r <= presc_hit ? 8'h00 : presc_r + 8'h01;
    end
  end

  // ===========================================================
  // Reset sequencer
  assign wd_reset_evt = (st_r == ST_RUN) && wd_timeout && !core_reset_r; // [RULE25]
  assign wake_go = (sleep_exit && !crystal)
                   || ((st_r == ST_OST) && ost_wake_r && (ost_cnt_r == OST_LAST));
  assign core_reset_nxt = dip_hold || pin_rst_r || (st_r == ST_POWER_UP_DELAY_TIMER)
                          || ((st_r == ST_OST) && !ost_wake_r) || wd_reset_evt;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_POWER_UP_DELAY_TIMER;
      power_up_delay_timer_cnt_r <= 11'h000;
      ost_cnt_r <= 11'h000;
      ost_wake_r <= 1'b0;
    end else if (dip_hold) begin // [RULE14]
      st_r <= ST_POWER_UP_DELAY_TIMER;
      power_up_delay_timer_cnt_r <= 11'h000;
      ost_wake_r <= 1'b0;
    end else begin
      unique case (st_r)
        ST_POWER_UP_DELAY_TIMER: begin
          // Delay entered only from power-on or dip, runs on the slow time base
          if (power_up_delay_disable || (tick && power_up_delay_timer_cnt_r == POWER_UP_DELAY_TIMER_LAST)) begin // [RULE15] [RULE16]
            st_r <= crystal ? ST_OST : ST_RUN;
            power_up_delay_timer_cnt_r <= 11'h000;
            ost_cnt_r <= 11'h000;
            ost_wake_r <= 1'b0;
          end else if (tick) begin
            power_up_delay_timer_cnt_r <= power_up_delay_timer_cnt_r + 11'h001;
          end
        end
        ST_OST: begin
          if (ost_cnt_r == OST_LAST) begin
            st_r <= ST_RUN;
            ost_wake_r <= 1'b0;
          end else begin
            ost_cnt_r <= ost_cnt_r + 11'h001;
          end
        end
        ST_RUN: begin
          if (sleep_cmd && !core_reset_r && !pin_rst_r && !wd_reset_evt) begin
            st_r <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (pin_rst_r) begin
            st_r <= ST_RUN;
          end else if (sleep_exit) begin // [RULE25]
            st_r <= crystal ? ST_OST : ST_RUN;
            ost_cnt_r <= 11'h000;
            ost_wake_r <= crystal;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_pc_r <= PC_RESET;
      wake_irq_r <= 1'b0;
    end else begin
      if (st_r == ST_RUN && sleep_cmd) begin
        sleep_pc_r <= core_pc;
      end
      if (sleep_exit) begin
        wake_irq_r <= irq_wake;
      end
    end
  end

  // ===========================================================
  // Core handshake: reset, restart address, vectoring
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_reset_r <= 1'b1;
      pc_load_r <= 1'b0;
      pc_load_addr_r <= PC_RESET;
    end else begin
      core_reset_r <= core_reset_nxt;
      pc_load_r <= (core_reset_r && !core_reset_nxt) || wake_go;
      if (wake_go) begin
        pc_load_addr_r <= sleep_pc_r + 13'h0001; // [RULE2] [RULE9]
      end else if (core_reset_r && !core_reset_nxt) begin
        pc_load_addr_r <= PC_RESET; // [RULE9]
      end
    end
  end

  // Vector only after the instruction following the sleep has retired
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vec_pending_r <= 1'b0;
      vector_jump_r <= 1'b0;
    end else begin
      vector_jump_r <= vec_pending_r && core_instr_done; // [RULE12]
      if (core_reset_r) begin
        vec_pending_r <= 1'b0;
      end else if (wake_go && (sleep_exit ? irq_wake : wake_irq_r) && global_irq_enable) begin
        vec_pending_r <= 1'b1; // [RULE12]
      end else if (core_instr_done) begin
        vec_pending_r <= 1'b0;
      end
    end
  end

  assign core_reset = core_reset_r;
  assign core_halt = (st_r == ST_SLEEP) || ((st_r == ST_OST) && ost_wake_r);
  assign pc_load = pc_load_r;
  assign pc_load_addr = pc_load_addr_r;
  assign vector_jump = vector_jump_r;
  assign vector_addr = PC_IRQ_VECTOR;

  // ===========================================================
  // Status flags; hardware events win over software writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_hi_r <= STATUS_HI_RST; // [RULE6] [RULE10]
      expiry_n_r <= 1'b1;
      sleep_n_r <= 1'b1;
    end else if (dip_hold) begin
      status_hi_r <= STATUS_HI_RST; // [RULE7] [RULE10]
      expiry_n_r <= 1'b1;
      sleep_n_r <= 1'b1;
    end else if (pin_fire && st_r == ST_SLEEP) begin
      status_hi_r <= STATUS_HI_RST; // [RULE8]
      expiry_n_r <= 1'b1;
      sleep_n_r <= 1'b0;
    end else if (pin_fire && st_r == ST_RUN) begin
      status_hi_r <= STATUS_HI_RST; // [RULE11]
    end else if (wd_reset_evt) begin
      status_hi_r <= STATUS_HI_RST; // [RULE7]
      expiry_n_r <= 1'b0;
      sleep_n_r <= 1'b1;
    end else if (sleep_exit && irq_wake) begin
      expiry_n_r <= 1'b1; // [RULE8] [RULE11]
      sleep_n_r <= 1'b0;
    end else if (sleep_exit) begin
      expiry_n_r <= 1'b0; // [RULE7] [RULE10]
      sleep_n_r <= 1'b0;
    end else if (st_r == ST_RUN && sleep_cmd) begin
      expiry_n_r <= 1'b1;
      sleep_n_r <= 1'b0;
    end else if (watchdog_clear_cmd) begin
      expiry_n_r <= 1'b1;
      sleep_n_r <= 1'b1;
    end else if (reg_wr && reg_addr == ADDR_STATUS) begin
      status_hi_r <= reg_wdata[7:5];
    end
  end

  // Cause bits: power-on clears the power-on bit and sets the dip bit, software sets; dip event beats a write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cause_por_r <= 1'b0; // [RULE24]
      cause_dip_r <= 1'b1;
      option_r <= OPTION_RST;
    end else begin
      if (reg_wr && reg_addr == ADDR_CAUSE) begin
        cause_por_r <= reg_wdata[1]; // [RULE24]
      end
      if (dip_hold) begin
        cause_dip_r <= 1'b0; // [RULE10]
      end else if (reg_wr && reg_addr == ADDR_CAUSE) begin
        cause_dip_r <= reg_wdata[0];
      end
      if (reg_wr && reg_addr == ADDR_OPTION) begin
        option_r <= reg_wdata;
      end
    end
  end

  // No reset at all: unknown after power-up, kept across every reset
  always_ff @(posedge clk) begin
    if (reg_wr && reg_addr == ADDR_STATUS) begin
      status_lo_r <= reg_wdata[2:0]; // [RULE1]
    end
    if (reg_wr && reg_addr == ADDR_KEEP) begin
      keep_r <= reg_wdata; // [RULE1]
    end
  end

  // ===========================================================
  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (!reg_rd) begin
      rdata_r <= 8'h00;
    end else begin
      unique case (reg_addr)
        ADDR_STATUS: rdata_r <= {status_hi_r, expiry_n_r, sleep_n_r, status_lo_r};
        ADDR_CAUSE: rdata_r <= {CAUSE_UNUSED, cause_por_r, cause_dip_r}; // [RULE13]
        ADDR_OPTION: rdata_r <= option_r;
        ADDR_WDT_CNT: rdata_r <= wd_base_r[9:2];
        ADDR_KEEP: rdata_r <= keep_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  // ===========================================================
  // Checks
  property p_pin_filter;
    @(posedge clk) disable iff (sys_rst)
    $rose(pin_rst_r) |-> $past(!pin_s, 1) && $past(!pin_s, 8);
  endproperty
  a_pin_filter: assert property (p_pin_filter) else $error("pin reset without long low"); // [RULE3]

  property p_pin_unused;
    @(posedge clk) disable iff (sys_rst)
    !ext_reset_pin_sel |=> !pin_rst_r;
  endproperty
  a_pin_unused: assert property (p_pin_unused) else $error("pin reset while internal"); // [RULE5]

  property p_wd_reset;
    @(posedge clk) disable iff (sys_rst)
    wd_reset_evt && !dip_hold && !pin_fire |=> core_reset_r && !expiry_n_r && sleep_n_r;
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("watchdog reset flags wrong"); // [RULE7]

  property p_wd_wake;
    @(posedge clk) disable iff (sys_rst)
    sleep_exit && !irq_wake && !dip_hold |=> !expiry_n_r && !sleep_n_r && !core_reset_r;
  endproperty
  a_wd_wake: assert property (p_wd_wake) else $error("watchdog wake wrong"); // [RULE25]

  property p_irq_wake;
    @(posedge clk) disable iff (sys_rst)
    sleep_exit && irq_wake && !dip_hold |=> expiry_n_r && !sleep_n_r;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq wake flags wrong"); // [RULE8]

  property p_reset_pc;
    @(posedge clk) disable iff (sys_rst)
    $fell(core_reset_r) |-> pc_load_r && (pc_load_addr_r == PC_RESET);
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("reset exit without pc 0"); // [RULE9]

  property p_vector;
    @(posedge clk) disable iff (sys_rst)
    vec_pending_r && core_instr_done |=> vector_jump_r ##1 !vector_jump_r;
  endproperty
  a_vector: assert property (p_vector) else $error("vector jump missing"); // [RULE12]

  property p_dip_hold;
    @(posedge clk) disable iff (sys_rst)
    dip_hold |=> core_reset_r && (st_r == ST_POWER_UP_DELAY_TIMER) && !cause_dip_r;
  endproperty
  a_dip_hold: assert property (p_dip_hold) else $error("dip did not hold reset"); // [RULE14]

  property p_ost_clear;
    @(posedge clk) disable iff (sys_rst)
    (st_r == ST_OST) |=> (wd_base_r == 10'h000);
  endproperty
  a_ost_clear: assert property (p_ost_clear) else $error("watchdog ran during start count"); // [RULE20]

  property p_power_up_delay_timer_skip;
    @(posedge clk) disable iff (sys_rst)
    (st_r == ST_POWER_UP_DELAY_TIMER) && power_up_delay_disable && !dip_hold |=> (st_r != ST_POWER_UP_DELAY_TIMER);
  endproperty
  a_power_up_delay_timer_skip: assert property (p_power_up_delay_timer_skip) else $error("disabled delay still ran"); // [RULE16]

  property p_por_sticky;
    @(posedge clk) disable iff (sys_rst)
    cause_por_r && !(reg_wr && reg_addr == ADDR_CAUSE) |=> cause_por_r;
  endproperty
  a_por_sticky: assert property (p_por_sticky) else $error("power-on bit lost"); // [RULE24]

endmodule

// ==== testbench/rwc_pin_model.sv ====
// Partner model: external reset pin with board driver and weak pull-up
`timescale 1ns/1ns
module rwc_pin_model (
  input wire logic clk,
  input wire logic press,
  input wire logic drv_out,
  input wire logic drv_oe,
  input wire logic pull_up,
  output logic level
);
  logic float_r = 1'b0;
  // ==========================================================
  // Pin resolution
  // Unpulled, undriven pin wanders so a stale level is never trusted
  always_ff @(posedge clk) begin
    float_r <= ~float_r;
  end
  always_comb begin
    if (press) begin
      level = 1'b0;
    end else if (drv_oe) begin
      level = drv_out;
    end else if (pull_up) begin
      level = 1'b1;
    end else begin
      level = float_r;
    end
  end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the reset and watchdog controller
`timescale 1ns/1ns
module tb;
  import rwc_pkg::*;
  localparam int TDIV = 4;
  localparam int DLY = POWER_UP_DELAY_TIMER_TICKS * TDIV;
  localparam int WDP = WDT_BASE_TICKS * TDIV;
  logic clk, sys_rst, supply_ok, dip_detect_en, press, pin_level, pin_out, pin_oe, pin_pu;
  logic ext_reset_pin_sel, power_up_delay_disable, watchdog_enable, watchdog_clear_cmd;
  logic sleep_cmd, irq_wake, global_irq_enable, core_instr_done, timer_tick, timer_evt;
  logic core_reset, core_halt, pc_load, vector_jump, reg_wr, reg_rd;
  logic [12:0] core_pc, pc_load_addr, vector_addr, last_pc;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  rwc_osc_t osc_mode;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_pcl = 0;
  int n_vec = 0;
  int n_tmr = 0;
  int n;

  rwc_pin_model pin (.clk(clk), .press(press), .drv_out(pin_out), .drv_oe(pin_oe),
    .pull_up(pin_pu), .level(pin_level));
  rwc_reset_ctrl #(.TICK_DIV(TDIV)) dut (.clk(clk), .sys_rst(sys_rst), .supply_ok(supply_ok),
    .dip_detect_en(dip_detect_en), .ext_reset_pin_in(pin_level), .ext_reset_pin_out(pin_out),
    .ext_reset_pin_oe(pin_oe), .ext_reset_pin_pu(pin_pu), .ext_reset_pin_sel(ext_reset_pin_sel),
    .power_up_delay_disable(power_up_delay_disable), .watchdog_enable(watchdog_enable),
    .osc_mode(osc_mode), .watchdog_clear_cmd(watchdog_clear_cmd), .sleep_cmd(sleep_cmd),
    .core_pc(core_pc), .irq_wake(irq_wake), .global_irq_enable(global_irq_enable),
    .core_instr_done(core_instr_done), .timer_evt(timer_evt), .timer_tick(timer_tick),
    .core_reset(core_reset), .core_halt(core_halt), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .vector_jump(vector_jump), .vector_addr(vector_addr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  // ==========================================================
  // Clock, monitors and common tasks
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (pc_load === 1'b1) begin
      last_pc <= pc_load_addr;
      n_pcl <= n_pcl + 1;
    end
    if (vector_jump === 1'b1) begin
      n_vec <= n_vec + 1;
    end
    if (timer_tick === 1'b1) begin
      n_tmr <= n_tmr + 1;
    end
  end
  task automatic complete_run;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic pulse(input int w);
    @(posedge clk) begin
      sleep_cmd <= (w == 0);
      core_instr_done <= (w == 1);
      watchdog_clear_cmd <= (w == 2);
      timer_evt <= (w == 3);
    end
    @(posedge clk) begin
      sleep_cmd <= 1'b0;
      core_instr_done <= 1'b0;
      watchdog_clear_cmd <= 1'b0;
      timer_evt <= 1'b0;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk) begin
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
    end
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk) begin
      reg_addr <= a;
      reg_rd <= 1'b1;
    end
    @(posedge clk) reg_rd <= 1'b0;
    @(negedge clk) v = reg_rdata;
  endtask
  task automatic wait_core(input logic v, input int lim, output int k);
    k = 0;
    while (core_reset !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic wait_pcl(input int lim, output int k);
    int base;
    base = n_pcl;
    k = 0;
    while (n_pcl == base && k < lim) begin
      @(posedge clk);
      k++;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_power_on;
    rd(ADDR_CAUSE, d);
    chk(d, 8'h01, "cause after power-on");
    rd(ADDR_STATUS, d);
    chk(d[7:3], 5'h03, "status after power-on");
    chk(pin_oe, 1'b0, "pin driven");
    chk(pin_pu, 1'b1, "pull-up");
    wait_core(1'b0, DLY + 100, n);
    chk(13'(n >= DLY - 20 && n < DLY + 100), 1, "power-up delay");
    cyc(3);
    chk(last_pc, 13'h0000, "reset vector");
  endtask
  task automatic t_regs;
    wr(ADDR_CAUSE, 8'h03);
    rd(ADDR_CAUSE, d);
    chk(d, 8'h03, "cause after set");
    wr(ADDR_KEEP, 8'hA5);
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, d);
    chk(d[4:3], 2'b11, "read-only flags");
    rd(3'h5, d);
    chk(d, 8'h00, "unmapped read");
  endtask
  task automatic t_pin;
    @(posedge clk) press <= 1'b1;
    cyc(20);
    @(posedge clk) press <= 1'b0;
    cyc(60);
    chk(core_reset, 1'b0, "glitch rejected");
    @(posedge clk) press <= 1'b1;
    wait_core(1'b1, 70, n);
    chk(core_reset, 1'b1, "long pulse resets");
    @(posedge clk) press <= 1'b0;
    wait_core(1'b0, 20, n);
    cyc(3);
    chk(last_pc, 13'h0000, "pin reset vector");
    rd(ADDR_STATUS, d);
    chk(d[7:3], 5'h03, "pin reset status");
    rd(ADDR_KEEP, d);
    chk(d, 8'hA5, "scratch kept");
    rd(ADDR_CAUSE, d);
    chk(d, 8'h03, "cause kept");
    @(posedge clk) ext_reset_pin_sel <= 1'b0;
    @(posedge clk) press <= 1'b1;
    cyc(100);
    chk(core_reset, 1'b0, "internal reset mode");
    @(posedge clk) press <= 1'b0;
    ext_reset_pin_sel <= 1'b1;
    cyc(10);
  endtask
  task automatic t_irq_wake;
    int v0;
    global_irq_enable <= 1'b1;
    @(posedge clk) core_pc <= 13'h0123;
    pulse(0);
    cyc(2);
    chk(core_halt, 1'b1, "halted");
    @(posedge clk) irq_wake <= 1'b1;
    wait_pcl(20, n);
    @(posedge clk) irq_wake <= 1'b0;
    chk(last_pc, 13'h0124, "irq resume");
    rd(ADDR_STATUS, d);
    chk(d[7:3], 5'h02, "irq wake status");
    v0 = n_vec;
    pulse(1);
    cyc(3);
    chk(13'(n_vec - v0), 1, "vector after one instr");
    chk(vector_addr, 13'h0004, "vector");
  endtask
  task automatic t_watchdog;
    wr(ADDR_OPTION, 8'h09);
    @(posedge clk) watchdog_enable <= 1'b1;
    cyc(3000);
    pulse(2);
    wait_core(1'b1, 3 * WDP, n);
    chk(13'(n > 2 * WDP - 24 && n < 2 * WDP + 24), 1, "ratio 1:2 timeout");
    wait_core(1'b0, 20, n);
    cyc(3);
    chk(last_pc, 13'h0000, "watchdog reset vector");
    rd(ADDR_STATUS, d);
    chk(d[4:3], 2'b01, "watchdog reset flags");
    wr(ADDR_OPTION, 8'h08);
    pulse(2);
    @(posedge clk) core_pc <= 13'h0200;
    pulse(0);
    wait_pcl(2 * WDP, n);
    chk(13'(n > WDP - 24 && n < WDP + 24), 1, "ratio 1:1 wake");
    chk(last_pc, 13'h0201, "watchdog wake resume");
    rd(ADDR_STATUS, d);
    chk(d[4:3], 2'b00, "watchdog wake flags");
    rd(ADDR_KEEP, d);
    chk(d, 8'hA5, "wake keeps scratch");
    n = n_vec;
    pulse(1);
    cyc(2);
    chk(13'(n_vec - n), 0, "no vector on watchdog wake");
    @(posedge clk) watchdog_enable <= 1'b0;
    cyc(2 * WDP);
    chk(core_reset, 1'b0, "disabled watchdog");
    wr(ADDR_OPTION, 8'h00);
    n = n_tmr;
    pulse(3);
    pulse(3);
    cyc(2);
    chk(13'(n_tmr - n), 1, "timer prescale 1:2");
  endtask
  task automatic t_dip;
    @(posedge clk) begin
      dip_detect_en <= 1'b1;
      supply_ok <= 1'b0;
    end
    wait_core(1'b1, 10, n);
    chk(core_reset, 1'b1, "dip holds reset");
    rd(ADDR_CAUSE, d);
    chk(d, 8'h02, "dip cause");
    rd(ADDR_STATUS, d);
    chk(d[4:3], 2'b11, "dip flags");
    cyc(DLY + 50);
    chk(core_reset, 1'b1, "still held low supply");
    @(posedge clk) supply_ok <= 1'b1;
    wait_core(1'b0, DLY + 100, n);
    chk(13'(n >= DLY - 20 && n < DLY + 100), 1, "delay after dip");
    @(posedge clk) begin
      power_up_delay_disable <= 1'b1;
      supply_ok <= 1'b0;
    end
    cyc(5);
    @(posedge clk) supply_ok <= 1'b1;
    wait_core(1'b0, 30, n);
    chk(13'(n < 30), 1, "delay skipped");
    @(posedge clk) begin
      osc_mode <= RWC_OSC_CRYSTAL;
      supply_ok <= 1'b0;
    end
    cyc(5);
    @(posedge clk) supply_ok <= 1'b1;
    wait_core(1'b0, OST_CYCLES + 60, n);
    chk(13'(n >= OST_CYCLES && n < OST_CYCLES + 60), 1, "start count");
  endtask

  // ==========================================================
  // Main sequence and watchdog on the run
  initial begin
    sys_rst = 1'b1;
    supply_ok = 1'b1;
    dip_detect_en = 1'b0;
    press = 1'b0;
    ext_reset_pin_sel = 1'b1;
    power_up_delay_disable = 1'b0;
    watchdog_enable = 1'b0;
    osc_mode = RWC_OSC_INTERNAL;
    watchdog_clear_cmd = 1'b0;
    sleep_cmd = 1'b0;
    core_pc = 13'h0000;
    irq_wake = 1'b0;
    global_irq_enable = 1'b0;
    core_instr_done = 1'b0;
    timer_evt = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cyc(8);
    @(posedge clk) sys_rst <= 1'b0;
    t_power_on();
    t_regs();
    t_pin();
    t_irq_wake();
    t_watchdog();
    t_dip();
    complete_run();
  end
  initial begin
    cyc(80000);
    n_mismatch++;
    complete_run();
  end
endmodule
